// ===== backlight_pwm_string_config.sv
// register bank for pwm generator, boost switcher and led string enables
`timescale 1ns/1ps
module backlight_pwm_string_config (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        reset_i,
	// register port from the serial interface
	input  wire logic        reg_wr_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic      [7:0]  reg_rdata_o,
	// nonvolatile defaults, valid when load strobe high
	input  wire logic        nv_load_i,
	input  wire logic [7:0]  nv_pwm_gen_i,
	input  wire logic [7:0]  nv_boost_i,
	input  wire logic [7:0]  nv_string_enable_i,
	// resistor pin measurement
	input  wire logic [2:0]  pin_freq_code_i,
	input  wire logic        pin_fault_i,
	// system state
	input  wire logic        auto_config_i,
	input  wire logic        backlight_on_i,
	input  wire logic [5:0]  string_open_i,
	input  wire logic [5:0]  string_short_i,
	// outputs to generator and analog
	output logic      [2:0]  pwm_out_freq_code_o,
	output logic      [2:0]  dim_threshold_o,
	output logic      [1:0]  pwm_bits_sel_o,
	output logic             inductor_large_o,
	output logic             switcher_freq_select_o,
	output logic      [1:0]  string_overvoltage_level_o,
	output logic      [5:0]  string_active_o,
	output logic             rephase_o
);
	logic [7:0] pwm_gen_reg;
	logic [7:0] boost_reg;
	logic [7:0] string_enable_reg;
	logic       source_pin_reg;
	logic       switcher_freq_reg;
	logic [5:0] removed_reg;
	logic [5:0] removed_next;
	logic [2:0] active_freq;
	logic [2:0] thresh;
	logic [5:0] enables;
	logic [5:0] fault;
	logic       wr_take;
	logic       wr_pwm_gen_register;
	logic       wr_boost;
	logic       wr_enable;
	logic       addr_mapped;

	// one compare shared by the write strobes and read mux; the register update below compares reg_addr_i directly
	function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
		return addr == target;
	endfunction

	// nonvolatile load wins over a host write in the same cycle
	assign wr_take     = reg_wr_i && !nv_load_i;
	assign wr_pwm_gen_register     = wr_take && addr_is(reg_addr_i, backlight_cfg_pkg::PWM_GEN_ADDR);
	assign wr_boost    = wr_take && addr_is(reg_addr_i, backlight_cfg_pkg::BOOST_ADDR);
	assign wr_enable   = wr_take && addr_is(reg_addr_i, backlight_cfg_pkg::STRING_ENABLE_ADDR);
	assign addr_mapped = addr_is(reg_addr_i, backlight_cfg_pkg::PWM_GEN_ADDR) ||
		addr_is(reg_addr_i, backlight_cfg_pkg::BOOST_ADDR) ||
		addr_is(reg_addr_i, backlight_cfg_pkg::STRING_ENABLE_ADDR);

	assign thresh  = pwm_gen_reg[backlight_cfg_pkg::THRESH_LSB +: 3];
	assign enables = string_enable_reg[5:0];
	// comparison happens in analog; detections arrive per string
	assign fault   = string_open_i | string_short_i;

	// pin measured every cycle regardless of select; chosen only if pin source latched
	assign active_freq = !source_pin_reg ? pwm_gen_reg[2:0] :
		(pin_fault_i ? backlight_cfg_pkg::FREQ_19K5 : pin_freq_code_i);

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			pwm_gen_reg       <= backlight_cfg_pkg::RESET_ALL;
			boost_reg         <= backlight_cfg_pkg::RESET_ALL;
			string_enable_reg <= backlight_cfg_pkg::RESET_ALL;
			source_pin_reg    <= 1'b0;
			switcher_freq_reg <= 1'b0;
		end else if (nv_load_i) begin
			pwm_gen_reg       <= nv_pwm_gen_i & ~backlight_cfg_pkg::RESERVED_MASK;
			boost_reg         <= nv_boost_i;
			string_enable_reg <= nv_string_enable_i;
			source_pin_reg    <= nv_pwm_gen_i[backlight_cfg_pkg::SOURCE_SEL_BIT];
			switcher_freq_reg <= nv_boost_i[backlight_cfg_pkg::SW_FREQ_BIT];
		end else if (reg_wr_i) begin
			if (reg_addr_i == backlight_cfg_pkg::PWM_GEN_ADDR) begin
				pwm_gen_reg <= reg_wdata_i & ~backlight_cfg_pkg::RESERVED_MASK;
				// a write may only drop back to the register source, never select the pin
				if (!reg_wdata_i[backlight_cfg_pkg::SOURCE_SEL_BIT]) begin
					source_pin_reg <= 1'b0;
				end
			end
			if (reg_addr_i == backlight_cfg_pkg::BOOST_ADDR) begin
				boost_reg <= reg_wdata_i;
			end
			if (reg_addr_i == backlight_cfg_pkg::STRING_ENABLE_ADDR) begin
				string_enable_reg <= reg_wdata_i;
			end
		end
	end

	// removal is held while faulty; a string returns once neither open nor shorted
	assign removed_next = auto_config_i ?
		((removed_reg | (fault & enables)) & string_open_i) | (fault & enables) : 6'h00;

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			removed_reg <= 6'h00;
			rephase_o   <= 1'b0;
		end else begin
			removed_reg <= removed_next;
			rephase_o   <= removed_next != removed_reg;
		end
	end

	// enable bit gates every string, auto only removes
	assign string_active_o = backlight_on_i ? (enables & ~removed_reg) : 6'h00;

	assign pwm_out_freq_code_o        = active_freq;
	assign dim_threshold_o            = thresh;
	// bit width select: 2 at the all-pwm threshold, 1 at the 25 percent threshold, 0 at every other setting
	assign pwm_bits_sel_o = (thresh == backlight_cfg_pkg::THRESH_ALL_PWM) ? 2'h2 :
		(thresh == backlight_cfg_pkg::THRESH_PWM_25) ? 2'h1 : 2'h0;
	assign inductor_large_o           = boost_reg[backlight_cfg_pkg::IND_SIZE_BIT];
	assign switcher_freq_select_o     = switcher_freq_reg;
	assign string_overvoltage_level_o = string_enable_reg[backlight_cfg_pkg::OV_LSB +: 2];

	always_comb begin
		reg_rdata_o = 8'h00;
		if (addr_is(reg_addr_i, backlight_cfg_pkg::PWM_GEN_ADDR)) begin
			reg_rdata_o = {pwm_gen_reg[7], 1'b0, pwm_gen_reg[5:3], active_freq};
		end else if (addr_is(reg_addr_i, backlight_cfg_pkg::BOOST_ADDR)) begin
			reg_rdata_o = boost_reg;
		end else if (addr_is(reg_addr_i, backlight_cfg_pkg::STRING_ENABLE_ADDR)) begin
			reg_rdata_o = string_enable_reg;
		end
	end

	// steps of the automatic string removal, shared by the properties below
	sequence auto_run_s;
		auto_config_i && backlight_on_i;
	endsequence
	sequence short_hit_s;
		auto_config_i && backlight_on_i && string_short_i[2] && enables[2];
	endsequence
	sequence open_hold_s;
		auto_config_i && removed_reg[0] && string_open_i[0];
	endsequence
	sequence clear_s;
		auto_config_i && removed_reg[2] && !string_open_i[2] && !string_short_i[2];
	endsequence

	// reset state
	reset_regs_a: assert property (@(posedge core_clk_i)
		reset_i |=> pwm_gen_reg == backlight_cfg_pkg::RESET_ALL &&
		boost_reg == backlight_cfg_pkg::RESET_ALL && string_enable_reg == backlight_cfg_pkg::RESET_ALL)
		else $error("registers not cleared by reset");
	reset_state_a: assert property (@(posedge core_clk_i)
		reset_i |=> !source_pin_reg && !switcher_freq_reg && removed_reg == 6'h00 && !rephase_o)
		else $error("state not cleared by reset");

	// nonvolatile load
	nv_pwm_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		nv_load_i |=> pwm_gen_reg == ($past(nv_pwm_gen_i) & ~backlight_cfg_pkg::RESERVED_MASK))
		else $error("pwm default not loaded");
	nv_boost_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		nv_load_i |=> boost_reg == $past(nv_boost_i))
		else $error("boost default not loaded");
	nv_enable_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		nv_load_i |=> string_enable_reg == $past(nv_string_enable_i))
		else $error("enable default not loaded");
	nv_source_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		nv_load_i |=> source_pin_reg == $past(nv_pwm_gen_i[backlight_cfg_pkg::SOURCE_SEL_BIT]))
		else $error("source select not loaded");
	nv_switcher_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		nv_load_i |=>
		switcher_freq_select_o == $past(nv_boost_i[backlight_cfg_pkg::SW_FREQ_BIT]))
		else $error("switcher default not loaded");

	// host writes
	source_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wr_pwm_gen_register && !source_pin_reg |=> !source_pin_reg)
		else $error("write selected pin source");
	pin_kept_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wr_pwm_gen_register && reg_wdata_i[backlight_cfg_pkg::SOURCE_SEL_BIT] |=> $stable(source_pin_reg))
		else $error("write changed active source");
	source_clear_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wr_pwm_gen_register && !reg_wdata_i[backlight_cfg_pkg::SOURCE_SEL_BIT] |=> !source_pin_reg)
		else $error("cleared select kept pin source");
	pwm_gen_register_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wr_pwm_gen_register |=> pwm_gen_reg == ($past(reg_wdata_i) & ~backlight_cfg_pkg::RESERVED_MASK))
		else $error("pwm register write lost");
	thresh_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wr_pwm_gen_register |=> dim_threshold_o == $past(reg_wdata_i[backlight_cfg_pkg::THRESH_LSB +: 3]))
		else $error("threshold write lost");
	boost_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wr_boost |=> boost_reg == $past(reg_wdata_i))
		else $error("boost register write lost");
	ind_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wr_boost |=> inductor_large_o == $past(reg_wdata_i[backlight_cfg_pkg::IND_SIZE_BIT]))
		else $error("inductor write lost");
	switcher_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wr_boost |=> $stable(switcher_freq_select_o))
		else $error("write moved switcher freq");
	switcher_nv_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!nv_load_i |=> $stable(switcher_freq_select_o))
		else $error("switcher freq changed");
	enable_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wr_enable |=> string_enable_reg == $past(reg_wdata_i))
		else $error("enable register write lost");
	ov_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wr_enable |=>
		string_overvoltage_level_o == $past(reg_wdata_i[backlight_cfg_pkg::OV_LSB +: 2]))
		else $error("overvoltage write lost");
	regs_idle_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!nv_load_i && !reg_wr_i |=>
		$stable(pwm_gen_reg) && $stable(boost_reg) && $stable(string_enable_reg))
		else $error("register moved without write");
	unmapped_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wr_take && !addr_mapped |=>
		$stable(pwm_gen_reg) && $stable(boost_reg) && $stable(string_enable_reg))
		else $error("unmapped write landed");

	// active frequency
	reg_code_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!source_pin_reg |-> pwm_out_freq_code_o == pwm_gen_reg[2:0])
		else $error("register code not applied");
	fault_ignored_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!source_pin_reg && pin_fault_i |-> pwm_out_freq_code_o == pwm_gen_reg[2:0])
		else $error("pin fault leaked into register source");
	pin_code_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		source_pin_reg && !pin_fault_i |-> pwm_out_freq_code_o == pin_freq_code_i)
		else $error("pin code not applied");
	pin_fault_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		source_pin_reg && pin_fault_i |-> pwm_out_freq_code_o == backlight_cfg_pkg::FREQ_19K5)
		else $error("faulty pin not forced");
	freq_stable_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!nv_load_i && !wr_pwm_gen_register && !source_pin_reg |=> $stable(pwm_out_freq_code_o))
		else $error("register code moved without write");

	// read path
	readback_freq_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		reg_addr_i == backlight_cfg_pkg::PWM_GEN_ADDR |-> reg_rdata_o[2:0] == pwm_out_freq_code_o)
		else $error("read not active code");
	pin_fault_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		source_pin_reg && pin_fault_i && reg_addr_i == backlight_cfg_pkg::PWM_GEN_ADDR
		|-> reg_rdata_o[2:0] == backlight_cfg_pkg::FREQ_19K5)
		else $error("read not forced code");
	source_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		reg_addr_i == backlight_cfg_pkg::PWM_GEN_ADDR
		|-> reg_rdata_o[7] == pwm_gen_reg[backlight_cfg_pkg::SOURCE_SEL_BIT])
		else $error("stored select not read");
	thresh_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		reg_addr_i == backlight_cfg_pkg::PWM_GEN_ADDR |-> reg_rdata_o[5:3] == dim_threshold_o)
		else $error("threshold not read");
	reserved_zero_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		reg_addr_i == backlight_cfg_pkg::PWM_GEN_ADDR |-> !reg_rdata_o[6])
		else $error("reserved bit set");
	reserved_reg_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!pwm_gen_reg[backlight_cfg_pkg::RESERVED_BIT])
		else $error("reserved bit stored");
	boost_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		reg_addr_i == backlight_cfg_pkg::BOOST_ADDR |-> reg_rdata_o == boost_reg)
		else $error("boost not read");
	enable_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		reg_addr_i == backlight_cfg_pkg::STRING_ENABLE_ADDR |-> reg_rdata_o == string_enable_reg)
		else $error("enables not read");
	unmapped_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!addr_mapped |-> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");

	// generator and analog settings
	thresh_out_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		dim_threshold_o == pwm_gen_reg[backlight_cfg_pkg::THRESH_LSB +: 3])
		else $error("threshold output wrong");
	bits_full_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		dim_threshold_o == backlight_cfg_pkg::THRESH_ALL_PWM |-> pwm_bits_sel_o == 2'h2)
		else $error("all pwm not 12-bit");
	bits_ten_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		dim_threshold_o == backlight_cfg_pkg::THRESH_PWM_25 |-> pwm_bits_sel_o == 2'h1)
		else $error("quarter threshold not 10-bit");
	bits_current_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		dim_threshold_o == backlight_cfg_pkg::THRESH_ALL_CURRENT |-> pwm_bits_sel_o == 2'h0)
		else $error("current dimming used pwm");
	inductor_sel_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		inductor_large_o == boost_reg[backlight_cfg_pkg::IND_SIZE_BIT])
		else $error("inductor range wrong");
	ov_level_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		string_overvoltage_level_o == string_enable_reg[backlight_cfg_pkg::OV_LSB +: 2])
		else $error("overvoltage level wrong");

	// string enables and automatic removal
	disabled_off_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(string_active_o & ~string_enable_reg[5:0]) == 6'h00)
		else $error("disabled string active");
	dark_off_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!backlight_on_i |-> string_active_o == 6'h00)
		else $error("string active while dark");
	manual_on_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!auto_config_i && backlight_on_i && $past(!auto_config_i)
		|-> string_active_o == string_enable_reg[5:0])
		else $error("manual string dropped");
	auto_clear_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!auto_config_i |=> removed_reg == 6'h00)
		else $error("removal kept without auto");
	removed_gap_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(string_active_o & removed_reg) == 6'h00)
		else $error("removed string active");
	fault_remove_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		auto_run_s ##0 fault[0] && enables[0] ##1 auto_run_s |-> !string_active_o[0])
		else $error("faulty string kept");
	short_remove_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		short_hit_s ##1 auto_run_s |-> !string_active_o[2])
		else $error("shorted string kept");
	open_hold_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		open_hold_s |=> removed_reg[0])
		else $error("open string added back");
	readd_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		clear_s |=> !removed_reg[2])
		else $error("recovered string not added back");
	rephase_match_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		rephase_o == $changed(removed_reg))
		else $error("rephase not matching removal change");
	rephase_idle_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		!auto_config_i && $past(!auto_config_i) && $past(!auto_config_i, 2) |-> !rephase_o)
		else $error("rephase without auto");
endmodule

// ===== backlight_cfg_pkg.sv
// package with offsets, field positions and reset values of the backlight configuration bank
package backlight_cfg_pkg;
	localparam logic [7:0] PWM_GEN_ADDR       = 8'h12;
	localparam logic [7:0] BOOST_ADDR         = 8'h13;
	localparam logic [7:0] STRING_ENABLE_ADDR = 8'h14;
	localparam int         SOURCE_SEL_BIT     = 7;
	localparam int         RESERVED_BIT       = 6;
	localparam int         THRESH_LSB         = 3;
	localparam int         IND_SIZE_BIT       = 1;
	localparam int         SW_FREQ_BIT        = 0;
	localparam int         OV_LSB             = 6;
	localparam logic [2:0] FREQ_4K9           = 3'h0;
	localparam logic [2:0] FREQ_9K8           = 3'h1;
	localparam logic [2:0] FREQ_19K5          = 3'h3;
	localparam logic [2:0] FREQ_39K1          = 3'h7;
	localparam logic [2:0] THRESH_ALL_CURRENT = 3'h0;
	localparam logic [2:0] THRESH_PWM_25      = 3'h5;
	localparam logic [2:0] THRESH_ALL_PWM     = 3'h7;
	localparam logic [7:0] RESERVED_MASK      = 8'h40;
	localparam logic [7:0] RESET_ALL          = 8'h00;
endpackage

// ===== reg_host.sv
// host model writing the configuration registers
`timescale 1ns/1ps
module reg_host (
	input  wire logic       clk_i,
	output logic            wr_o,
	output logic      [7:0] addr_o,
	output logic      [7:0] wdata_o
);
	initial begin
		wr_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end
	// data is scrambled once the strobe drops so stale values cannot pass
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
		#1;
	endtask
	task automatic look(input logic [7:0] a);
		@(posedge clk_i);
		addr_o <= a;
		@(posedge clk_i);
		#1;
	endtask
endmodule

// ===== tb_top.sv
// self-checking bench for the backlight configuration bank
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0, rst = 1'b1, nv_ld = 1'b0, fault = 1'b0, auto_on = 1'b0, bl_on = 1'b1;
	logic [7:0] nv_pg = 8'h00, nv_bo = 8'h00, nv_se = 8'h00, rdata, addr, wdata;
	logic [2:0] pin = 3'h5, fcode, thr;
	logic [5:0] open_s = 6'h00, short_s = 6'h00, act;
	logic [1:0] bits, ovl;
	logic wr, ind, swf, reph;
	int fails = 0, check_count = 0;
	reg_host h (.clk_i(clk), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));
	backlight_pwm_string_config i_backlight_pwm_string_config (.core_clk_i(clk), .reset_i(rst),
		.reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.nv_load_i(nv_ld), .nv_pwm_gen_i(nv_pg), .nv_boost_i(nv_bo), .nv_string_enable_i(nv_se),
		.pin_freq_code_i(pin), .pin_fault_i(fault), .auto_config_i(auto_on),
		.backlight_on_i(bl_on), .string_open_i(open_s), .string_short_i(short_s),
		.pwm_out_freq_code_o(fcode), .dim_threshold_o(thr), .pwm_bits_sel_o(bits),
		.inductor_large_o(ind), .switcher_freq_select_o(swf),
		.string_overvoltage_level_o(ovl), .string_active_o(act), .rephase_o(reph));
	initial forever #12.5 clk = ~clk;
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic t_freq;
		logic [2:0] fc[4] = '{3'h0, 3'h1, 3'h3, 3'h7};
		logic [2:0] th[4] = '{3'h0, 3'h5, 3'h7, 3'h5};
		logic [1:0] pb[4] = '{2'h0, 2'h1, 2'h2, 2'h1};
		for (int i = 0; i < 4; i++) begin
			h.put(8'h12, {2'b01, th[i], fc[i]});
			h.look(8'h12);
			chk("freq", fcode, fc[i]);
			chk("pwm_gen_register", rdata, {2'b00, th[i], fc[i]});
			chk("thr", thr, th[i]);
			chk("bits", bits, pb[i]);
		end
	endtask
	task automatic t_source;
		h.put(8'h12, 8'h81);
		chk("wr sel", fcode, 3'h1);
		@(posedge clk);
		{nv_pg, nv_bo, nv_se, nv_ld} <= {8'h80, 8'h01, 8'h3f, 1'b1};
		@(posedge clk);
		nv_ld <= 1'b0;
		#1;
		chk("pin", fcode, 3'h5);
		chk("pin rd", rdata[2:0], 3'h5);
		chk("sw", swf, 1'b1);
		chk("nv en", act, 6'h3f);
		@(posedge clk);
		fault <= 1'b1;
		#1;
		chk("fault", fcode, 3'h3);
		h.put(8'h13, 8'h02);
		chk("ind", ind, 1'b1);
		chk("sw wr", swf, 1'b1);
		h.put(8'h12, 8'h06);
		chk("reg src", fcode, 3'h6);
	endtask
	task automatic t_string;
		h.put(8'h14, 8'hc5);
		chk("en rd", rdata, 8'hc5);
		chk("ov", ovl, 2'h3);
		chk("act", act, 6'h05);
		h.look(8'h20);
		chk("unmapped", rdata, 8'h00);
		@(posedge clk);
		{auto_on, open_s, short_s} <= {1'b1, 6'h03, 6'h04};
		@(posedge clk);
		#1;
		chk("removed", act, 6'h00);
		chk("rephase", reph, 1'b1);
		@(posedge clk);
		open_s <= 6'h00;
		short_s <= 6'h00;
		#1;
		chk("rephase end", reph, 1'b0);
		@(posedge clk);
		#1;
		chk("readd", act, 6'h05);
		chk("rephase add", reph, 1'b1);
		@(posedge clk);
		bl_on <= 1'b0;
		#1;
		chk("dark", act, 6'h00);
	endtask
	initial begin
		#20000;
		fails++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_freq();
		t_source();
		t_string();
		wrap_up();
	end
endmodule
